// ### dv/smk_far.sv
`timescale 1ns/1ps
module smk_far
(
  // clock
  input wire logic sys_clk_i,
  // interconnect pin of the unit under test
  input wire logic io_o_i,
  input wire logic io_oe_n_i,
  // another detector pulling the shared line high
  input wire logic peer_drive_i,
  // sound code seen by the sound chip
  input wire smk_pkg::smk_sound_s sound_i,
  // resolved line level and latched code
  output logic line_o,
  output logic [2:0] code_o
);
  import smk_pkg::*;
  // a driving unit wins; released, the line follows the peer drive
  assign line_o = !io_oe_n_i ? io_o_i : peer_drive_i;
  // sound chip latches the code on every rising edge
  always_ff @(posedge sys_clk_i)
  begin
    code_o <= sound_i;
  end
endmodule // smk_far

// ### dv/smk_seq_test.sv
`timescale 1ns/1ps
`include "smk_params.svh"
module smk_seq_test;
  import smk_pkg::*;
  localparam int HUSH = 32;
  localparam int LIMIT = 30000;
  // stimulus
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic en = 1'b1;
  logic smoke = 1'b0, test = 1'b0, quiet = 1'b0, lowb = 1'b0, chbad = 1'b0, peer = 1'b0;
  smk_avs_req_s req = '0;
  // observed
  logic io_o, io_oe_n, strobe, ired, led, horn, hg, lg, boost, tmode, line, wreq;
  logic [2:0] code;
  logic [2:0] wcode;
  logic [31:0] rdata, q;
  smk_sound_s sound;
  int mismatches = 0, num_checks = 0, cycles = 0, n;

  smk_seq #(.TIMER_CYC(16'h0020)) smk_seq_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .clk_en_i(en), .smoke_i(smoke), .test_i(test), .quiet_en_i(quiet), .low_batt_i(lowb),
    .chamber_bad_i(chbad), .io_i(line), .io_o(io_o), .io_oe_n_o(io_oe_n), .strobe_o(strobe),
    .ired_o(ired), .led_o(led), .horn_o(horn), .high_gain_cap_o(hg), .low_gain_cap_o(lg),
    .gain_boost_o(boost), .timer_mode_o(tmode), .sound_o(sound), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));
  smk_far smk_far_i (.sys_clk_i(sys_clk_i), .io_o_i(io_o), .io_oe_n_i(io_oe_n),
    .peer_drive_i(peer), .sound_i(sound), .line_o(line), .code_o(code));

  // clock
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do
    begin
      @(posedge sys_clk_i);
    end
    while (wreq !== 1'b0); // loops until waitrequest is sampled low
    q = rdata;
    req <= '0;
    @(posedge sys_clk_i);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return horn;
      1: return !io_oe_n && !io_o;
      2: return tmode;
      default: return sound === wcode;
    endcase
  endfunction
  // run length of a level whose first sample was already seen
  task automatic phase(input int k, input logic v, output int r);
    r = 1;
    @(posedge sys_clk_i);
    while (sig(k) === v && r < 5000)
    begin
      r++;
      @(posedge sys_clk_i);
    end
  endtask
  task automatic wait_code(input logic [2:0] c, output int r);
    wcode = c;
    phase(4, 1'b0, r);
  endtask
  // edges to the next strobe whose gain select matches hs
  task automatic next_strobe(input logic hs, output int r);
    r = 0;
    do
    begin
      @(posedge sys_clk_i);
      r++;
    end
    while (!(strobe === 1'b1 && hg === hs) && r < 5000);
  endtask
  // sync to a long off gap, then one full group of three
  task automatic horn_pattern;
    int r;
    do phase(0, 1'b0, r); while (r < 144);
    for (int k = 0; k < 3; k++)
    begin
      phase(0, 1'b1, r);
      chk(r, 48);
      phase(0, 1'b0, r);
      chk(r, k < 2 ? 48 : 144);
    end
  endtask
  // chirp width and spacing; waits for a quiet gap first
  task automatic chirp(input int gap);
    int r;
    do phase(0, 1'b0, r); while (r < 100);
    phase(0, 1'b1, r);
    chk(r, 1);
    phase(0, 1'b0, r);
    chk(r + 1, gap);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // emitter and indicator never together; no indicator in remote alarm
  always @(posedge sys_clk_i)
  begin
    if (resetn_i && (ired === 1'b1 || sound === `SMK_CODE_REMOTE))
      chk(led, 1'b0);
  end
  // hang guard
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    cyc(20);
    chk({sound, lg, io_oe_n, wreq}, 6'h07);
    resetn_i <= 1'b1;
    cyc(1);
    bus(1'b0, `SMK_REG_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `SMK_REG_CTRL, 32'h1);
    bus(1'b0, `SMK_REG_CTRL, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 4'h8, 32'hffffffff);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `SMK_REG_STAT, 32'hffffffff);
    bus(1'b0, `SMK_REG_STAT, 32'h0);
    chk(q[2:0], `SMK_CODE_STBY);
    $display("registers done");
    // standby cadence, blink on; then smoke speeds sampling up
    next_strobe(1'b0, n);
    next_strobe(1'b0, n);
    chk(n, 210);
    bus(1'b1, `SMK_REG_CTRL, 32'h0);
    next_strobe(1'b0, n);
    smoke <= 1'b1;
    next_strobe(1'b0, n);
    next_strobe(1'b0, n);
    chk(n, 192);
    next_strobe(1'b0, n);
    chk(n, 96);
    wait_code(`SMK_CODE_LOCAL, n);
    chk_rng(n, 1, 3);
    cyc(2);
    chk({io_oe_n, io_o, boost, lg}, 4'h7);
    chk(code, `SMK_CODE_LOCAL);
    horn_pattern();
    next_strobe(1'b0, n);
    next_strobe(1'b0, n);
    chk(n, 96);
    smoke <= 1'b0;
    phase(1, 1'b0, n);
    phase(1, 1'b1, n);
    chk(n, 96);
    $display("local alarm done");
    // short pulse rejected, long one qualifies
    peer <= 1'b1;
    cyc(8);
    peer <= 1'b0;
    cyc(20);
    chk(sound, `SMK_CODE_STBY);
    peer <= 1'b1;
    wait_code(`SMK_CODE_REMOTE, n);
    // less the code flop and the bench's own sampling edge
    chk_rng(n - 2, 9, 13);
    next_strobe(1'b0, n);
    next_strobe(1'b0, n);
    chk(n, 768);
    chk(code, `SMK_CODE_REMOTE);
    horn_pattern();
    peer <= 1'b0;
    wait_code(`SMK_CODE_STBY, n);
    $display("remote alarm done");
    // warnings
    lowb <= 1'b1;
    wait_code(`SMK_CODE_LOWBAT, n);
    phase(3, 1'b1, n);
    chk(n, 1);
    phase(3, 1'b0, n);
    chk(n + 1, 212);
    chirp(212);
    lowb <= 1'b0;
    chbad <= 1'b1;
    wait_code(`SMK_CODE_CHAMBER, n);
    chk(n < 5000, 1'b1);
    chirp(26);
    phase(0, 1'b1, n);
    phase(0, 1'b0, n);
    chk(n + 1, 26);
    chbad <= 1'b0;
    $display("warnings done");
    // passing push-test, release starts hush
    quiet <= 1'b1;
    test <= 1'b1;
    next_strobe(1'b1, n);
    next_strobe(1'b1, n);
    chk(n, 24);
    smoke <= 1'b1;
    wait_code(`SMK_CODE_PASS, n);
    chk_rng(n, 1, 80);
    cyc(2);
    chk({io_oe_n, io_o}, 2'b01);
    horn_pattern();
    test <= 1'b0;
    smoke <= 1'b0;
    phase(2, 1'b0, n);
    chk_rng(n, 1, 3);
    phase(2, 1'b1, n);
    chk(n, HUSH);
    phase(1, 1'b0, n);
    phase(1, 1'b1, n);
    chk(n, 96);
    $display("push-test pass done");
    // failing push-test
    quiet <= 1'b0;
    test <= 1'b1;
    cyc(150);
    chk({horn, io_oe_n}, 2'b01);
    test <= 1'b0;
    wait_code(`SMK_CODE_FAIL, n);
    chk_rng(n, 2048, 3072);
    wait_code(`SMK_CODE_STBY, n);
    chk_rng(n, 1, 1025);
    $display("push-test fail done");
    report_and_stop();
  end
endmodule // smk_seq_test

// ### logic/smk_horn.sv
`timescale 1ns/1ps
`include "smk_params.svh"
module smk_horn
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  // shared time base
  input wire smk_pkg::smk_tick_t now_i,
  // requests
  input wire logic pattern_i,
  input wire logic chirp_i,
  input wire logic triple_i,
  // horn enable
  output logic horn_o
);
  import smk_pkg::*;
  logic [2:0] ph_r;
  logic [1:0] left_r;
  logic horn_r;
  smk_tick_t ph_st_r;
  smk_tick_t ch_st_r;
  // phases 0,2,4 on; 1,3 short off; 5 long off
  wire smk_tick_t dur = (ph_r == 3'h5) ? `SMK_HORN_OFF_L :
    (ph_r[0] ? `SMK_HORN_OFF_S : `SMK_HORN_ON);
  wire ph_end = smk_since(now_i, ph_st_r) == dur - 16'h0001;
  wire fire = (left_r != 2'h0) && (smk_since(now_i, ch_st_r) == `SMK_CHIRP_GAP);

  // temporal pattern and chirp train share one output flop
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ph_r <= 3'h0;
      ph_st_r <= 16'h0000;
      left_r <= 2'h0;
      ch_st_r <= 16'h0000;
      horn_r <= 1'b0;
    end
    else if (en_i)
    begin
      if (!pattern_i)
      begin
        ph_r <= 3'h0;
        ph_st_r <= now_i + 16'h0001;
      end
      else if (ph_end)
      begin
        ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
        ph_st_r <= now_i + 16'h0001;
      end
      if (chirp_i)
      begin
        left_r <= triple_i ? 2'h3 : 2'h1;
        ch_st_r <= now_i - `SMK_CHIRP_GAP + 16'h0001;
      end
      else if (fire)
      begin
        left_r <= left_r - 2'h1;
        ch_st_r <= now_i;
      end
      horn_r <= pattern_i ? !ph_r[0] : fire;
    end
  end

  assign horn_o = horn_r;

  chk_chirp_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (en_i && horn_r && !pattern_i) |=> !horn_r)
    else $error("chirp longer than one cycle");
endmodule // smk_horn

// ### logic/smk_io_qual.sv
`timescale 1ns/1ps
`include "smk_params.svh"
module smk_io_qual
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  // shared time base
  input wire smk_pkg::smk_tick_t now_i,
  // line and local state
  input wire logic io_i,
  input wire logic local_i,
  // qualified remote alarm
  output logic remote_o
);
  import smk_pkg::*;
  logic [1:0] hits_r;
  logic [3:0] run_r;
  logic remote_r;
  // one slot in four is a sample; a low on any cycle restarts
  wire slot = (now_i & `SMK_IO_SLOT_MASK) == 16'h0000;
  wire blocked = local_i || !io_i;

  // three high slots then one more high cycle declares remote
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hits_r <= 2'h0;
      remote_r <= 1'b0;
    end
    else if (en_i)
    begin
      if (blocked)
      begin
        hits_r <= 2'h0;
        remote_r <= 1'b0;
      end
      else
      begin
        if (slot && hits_r != 2'h3)
          hits_r <= hits_r + 2'h1;
        if (hits_r == 2'h3)
          remote_r <= 1'b1;
      end
    end
  end

  // helper: run of high cycles, read only by a check
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      run_r <= 4'h0;
    else if (en_i)
      run_r <= !io_i ? 4'h0 : (run_r == 4'hf ? run_r : run_r + 4'h1);
  end

  assign remote_o = remote_r;

  chk_remote_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(remote_r) |-> run_r >= `SMK_IO_MIN_RUN)
    else $error("remote alarm after short pulse");
  chk_remote_local: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (en_i && local_i) |=> !remote_r)
    else $error("remote qualified during local alarm");
endmodule // smk_io_qual

// ### logic/smk_params.svh
`ifndef SMK_PARAMS_SVH
`define SMK_PARAMS_SVH

// sampling periods, oscillator cycles
`define SMK_P_IDLE 16'h00d2
`define SMK_P_ONE 16'h00c0
`define SMK_P_TWO 16'h0060
`define SMK_P_REMOTE 16'h0300
`define SMK_P_CHAMBER 16'h00da
`define SMK_P_TEST 16'h0018
// interconnect timing
`define SMK_DUMP 16'h0060
`define SMK_IO_SLOT_MASK 16'h0003
`define SMK_IO_MIN_RUN 4'h9
// warnings and horn
`define SMK_WARN_P 16'h00d4
`define SMK_CHIRP_GAP 16'h001a
`define SMK_HORN_ON 16'h0030
`define SMK_HORN_OFF_S 16'h0030
`define SMK_HORN_OFF_L 16'h0090
`define SMK_LED_P 16'h0030
// push-test and hush
`define SMK_FAIL_MIN 16'h0800
`define SMK_FAIL_MAX 16'h0c00
`define SMK_TIMER_CYC 16'he000
// sound codes
`define SMK_CODE_STBY 3'h0
`define SMK_CODE_LOCAL 3'h1
`define SMK_CODE_REMOTE 3'h2
`define SMK_CODE_PASS 3'h3
`define SMK_CODE_FAIL 3'h4
`define SMK_CODE_LOWBAT 3'h5
`define SMK_CODE_CHAMBER 3'h6
// register map, byte addresses
`define SMK_REG_CTRL 4'h0
`define SMK_REG_STAT 4'h4
`define SMK_CTRL_RST 1'b0
`endif

// ### logic/smk_pkg.sv
package smk_pkg;
  typedef logic [15:0] smk_tick_t;
  typedef enum logic [2:0] {ST_STBY, ST_TEST, ST_PASS, ST_FWAIT, ST_FAIL} smk_state_e;
  typedef struct packed {
    logic sound_ctrl_bit2;
    logic sound_ctrl_bit1;
    logic sound_ctrl_bit0;
  } smk_sound_s;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } smk_avs_req_s;
  // cycles elapsed since a stamp; wraps cleanly on the 16-bit base
  function automatic smk_tick_t smk_since(input smk_tick_t now, input smk_tick_t st);
    return now - st;
  endfunction
endpackage

// ### logic/smk_seq.sv
`timescale 1ns/1ps
`include "smk_params.svh"
module smk_seq
#(
  // hush length, shortened in simulation
  parameter smk_pkg::smk_tick_t TIMER_CYC = `SMK_TIMER_CYC
)
(
  // clock, reset, oscillator tick
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // sensing and user inputs
  input wire logic smoke_i,
  input wire logic test_i,
  input wire logic quiet_en_i,
  input wire logic low_batt_i,
  input wire logic chamber_bad_i,
  // interconnect pin
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_n_o,
  // chamber, indicator, horn
  output logic strobe_o,
  output logic ired_o,
  output logic led_o,
  output logic horn_o,
  // amplifier gain selects and hush timer mode
  output logic high_gain_cap_o,
  output logic low_gain_cap_o,
  output logic gain_boost_o,
  output logic timer_mode_o,
  // sound IC code
  output smk_pkg::smk_sound_s sound_o,
  // register bus
  input wire smk_pkg::smk_avs_req_s avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import smk_pkg::*;

  smk_tick_t now_r;
  smk_tick_t smp_st_r;
  smk_tick_t chm_st_r;
  smk_tick_t led_st_r;
  smk_tick_t warn_st_r;
  smk_tick_t rel_st_r;
  smk_tick_t tmr_st_r;
  smk_tick_t dmp_st_r;
  smk_state_e state_r;
  logic [1:0] vcnt_r;
  logic [1:0] pcnt_r;
  logic [1:0] fcnt_r;
  logic local_r;
  logic pend_r;
  logic chm_pend_r;
  logic test_q_r;
  logic dump_r;
  logic timer_r;
  logic blink_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic strobe_r;
  logic ired_r;
  logic led_r;
  logic hg_r;
  logic lg_r;
  logic io_r;
  logic oe_n_r;
  smk_sound_s sound_r;
  logic remote;
  logic [7:0] dmp_len_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // mode decode
  wire stby = state_r == ST_STBY;
  wire in_test = (state_r == ST_TEST) || (state_r == ST_PASS);
  wire test_fall = test_q_r && !test_i;
  wire drive_hi = local_r || (state_r == ST_PASS);

  // sampling schedule; vcnt_r[1] means two or more valid samples
  wire smk_tick_t period = in_test ? `SMK_P_TEST :
    (local_r || vcnt_r[1]) ? `SMK_P_TWO :
    (vcnt_r == 2'h1) ? `SMK_P_ONE :
    remote ? `SMK_P_REMOTE : `SMK_P_IDLE;
  wire smk_tick_t smp_age = smk_since(now_r, smp_st_r);
  wire smp_due = smp_age >= period;
  // a chamber check keeps clear of a sample due now or next cycle, so that
  // sample keeps its own stamp and is not taken at high gain
  wire chm_due = stby && !local_r && (smp_age + 16'h0001 < period) &&
    smk_since(now_r, chm_st_r) >= `SMK_P_CHAMBER;
  wire strobe_nxt = smp_due || chm_due;

  // indicator: remote-only alarm gives no pulses at all
  wire led_alarm = local_r || in_test;
  wire smk_tick_t led_per = led_alarm ? `SMK_LED_P : (timer_r ? `SMK_P_IDLE : `SMK_WARN_P);
  wire led_en = led_alarm || (!remote && stby && (timer_r || blink_r));
  wire led_nxt = led_en && smk_since(now_r, led_st_r) >= led_per;
  // emitter yields to the indicator so its current spike cannot upset a sample
  wire ired_nxt = strobe_nxt && !led_nxt;

  // smoke results arrive the cycle after a strobe; chamber checks are not smoke
  wire smoke_hit = pend_r && !chm_pend_r && smoke_i;
  wire smoke_miss = pend_r && !chm_pend_r && !smoke_i;
  wire local_set = stby && !local_r && smoke_hit && (vcnt_r == 2'h2);
  wire local_end = local_r && smoke_miss;
  wire pass_exit = (state_r == ST_PASS) && !test_i && pend_r && (pcnt_r == 2'h2);
  wire dump_start = local_end || pass_exit;
  wire dump_done = dump_r && (smk_since(now_r, dmp_st_r) == `SMK_DUMP);

  // warnings only in quiet standby; low battery outranks the chamber
  wire warn_act = stby && !local_r && !remote && (low_batt_i || chamber_bad_i);
  wire warn_due = warn_act && smk_since(now_r, warn_st_r) >= `SMK_WARN_P;
  wire smk_tick_t rel_age = smk_since(now_r, rel_st_r);
  wire fail_show = (state_r == ST_FAIL) && (rel_age >= `SMK_FAIL_MIN);

  // gain select
  wire hg_nxt = (state_r == ST_TEST) || (state_r == ST_FWAIT) ||
    ((state_r == ST_PASS) && test_i) || chm_due || chm_pend_r;

  // sound code, highest priority first
  wire [2:0] code_nxt = local_r ? `SMK_CODE_LOCAL :
    (state_r == ST_PASS) ? `SMK_CODE_PASS :
    fail_show ? `SMK_CODE_FAIL :
    remote ? `SMK_CODE_REMOTE :
    warn_due ? (low_batt_i ? `SMK_CODE_LOWBAT : `SMK_CODE_CHAMBER) :
    `SMK_CODE_STBY;

  // bus decode
  wire req = avs_req_i.read || avs_req_i.write;
  wire acc = req && !wait_r;
  wire [31:0] rd_nxt = (avs_req_i.address == `SMK_REG_CTRL) ? {31'h0, blink_r} :
    (avs_req_i.address == `SMK_REG_STAT) ?
    {22'h0, timer_r, remote, local_r, dump_r, state_r, sound_r} : 32'h0;

  // single free-running time base; everything else stamps it
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      now_r <= 16'h0000;
    else if (clk_en_i)
      now_r <= now_r + 16'h0001;
  end

  // push-test sequence
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_STBY;
      pcnt_r <= 2'h0;
      fcnt_r <= 2'h0;
      rel_st_r <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      case (state_r)
        ST_STBY:
        begin
          pcnt_r <= 2'h0;
          fcnt_r <= 2'h0;
          if (test_i && !local_r)
            state_r <= ST_TEST;
        end
        ST_TEST:
        begin
          if (!test_i)
            state_r <= ST_STBY;
          else if (pend_r && smoke_i)
          begin
            pcnt_r <= pcnt_r + 2'h1;
            fcnt_r <= 2'h0;
            if (pcnt_r == 2'h2)
            begin
              state_r <= ST_PASS;
              pcnt_r <= 2'h0;
            end
          end
          else if (pend_r)
          begin
            pcnt_r <= 2'h0;
            fcnt_r <= fcnt_r + 2'h1;
            if (fcnt_r == 2'h2)
              state_r <= ST_FWAIT;
          end
        end
        ST_PASS:
        begin
          // three more strobes after release, then back to standby
          if (test_i)
            pcnt_r <= 2'h0;
          else if (pend_r)
            pcnt_r <= pcnt_r + 2'h1;
          if (pass_exit)
            state_r <= ST_STBY;
        end
        ST_FWAIT:
        begin
          if (!test_i)
          begin
            state_r <= ST_FAIL;
            rel_st_r <= now_r;
          end
        end
        ST_FAIL:
        begin
          if (test_i)
            state_r <= ST_TEST;
          else if (rel_age >= `SMK_FAIL_MAX - 16'h0001)
            state_r <= ST_STBY;
        end
        default:
          state_r <= ST_STBY;
      endcase
    end
  end

  // smoke speed-up and local alarm
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      vcnt_r <= 2'h0;
      local_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!stby || smoke_miss)
        vcnt_r <= 2'h0;
      else if (smoke_hit && vcnt_r != 2'h3)
        vcnt_r <= vcnt_r + 2'h1;
      if (local_set)
        local_r <= 1'b1;
      else if (local_end)
        local_r <= 1'b0;
    end
  end

  // schedule stamps
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      smp_st_r <= 16'h0000;
      chm_st_r <= 16'h0000;
      led_st_r <= 16'h0000;
      warn_st_r <= 16'h0000;
      pend_r <= 1'b0;
      chm_pend_r <= 1'b0;
      test_q_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pend_r <= strobe_nxt;
      chm_pend_r <= chm_due;
      test_q_r <= test_i;
      if (smp_due)
        smp_st_r <= now_r;
      if (chm_due)
        chm_st_r <= now_r;
      // restamp while idle so the first pulse comes a full period later
      if (led_nxt || !led_en)
        led_st_r <= now_r;
      if (warn_due || !warn_act)
        warn_st_r <= now_r;
    end
  end

  // hush timer and interconnect discharge
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      timer_r <= 1'b0;
      tmr_st_r <= 16'h0000;
      dump_r <= 1'b0;
      dmp_st_r <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      if (test_fall && quiet_en_i)
      begin
        timer_r <= 1'b1;
        tmr_st_r <= now_r;
      end
      else if (timer_r && smk_since(now_r, tmr_st_r) >= TIMER_CYC)
        timer_r <= 1'b0;
      if (dump_start)
      begin
        dump_r <= 1'b1;
        dmp_st_r <= now_r;
      end
      else if (dump_done)
        dump_r <= 1'b0;
    end
  end

  // output flops
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strobe_r <= 1'b0;
      ired_r <= 1'b0;
      led_r <= 1'b0;
      hg_r <= 1'b0;
      lg_r <= 1'b1;
      io_r <= 1'b0;
      oe_n_r <= 1'b1;
      sound_r <= `SMK_CODE_STBY;
    end
    else if (clk_en_i)
    begin
      strobe_r <= strobe_nxt;
      ired_r <= ired_nxt;
      led_r <= led_nxt;
      hg_r <= hg_nxt;
      lg_r <= !hg_nxt;
      io_r <= drive_hi;
      oe_n_r <= !(drive_hi || dump_r);
      sound_r <= code_nxt;
    end
  end

  // bus slave: waitrequest drops one cycle after a request appears
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
      blink_r <= `SMK_CTRL_RST;
    end
    else if (clk_en_i)
    begin
      if (req && wait_r)
      begin
        wait_r <= 1'b0;
        rdata_r <= rd_nxt;
      end
      else
        wait_r <= 1'b1;
      if (acc && avs_req_i.write && avs_req_i.address == `SMK_REG_CTRL)
        blink_r <= avs_req_i.writedata[0];
    end
  end

  smk_io_qual u_io
  (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .en_i(clk_en_i),
    .now_i(now_r),
    .io_i(io_i),
    .local_i(drive_hi), // our own drive must not qualify
    .remote_o(remote)
  );

  smk_horn u_horn
  (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .en_i(clk_en_i),
    .now_i(now_r),
    .pattern_i(local_r || remote || (state_r == ST_PASS)),
    .chirp_i(warn_due),
    .triple_i(!low_batt_i),
    .horn_o(horn_o)
  );

  assign strobe_o = strobe_r;
  assign ired_o = ired_r;
  assign led_o = led_r;
  assign high_gain_cap_o = hg_r;
  assign low_gain_cap_o = lg_r;
  assign gain_boost_o = local_r;
  assign timer_mode_o = timer_r;
  assign io_o = io_r;
  assign io_oe_n_o = oe_n_r;
  assign sound_o = sound_r;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

  // helper: enabled cycles the discharge has been on the pin
  wire dmp_pin = !oe_n_r && !io_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dmp_len_r <= 8'h0;
    else if (clk_en_i)
      dmp_len_r <= dmp_pin ? dmp_len_r + 8'h1 : 8'h0;
  end

  chk_ired_led: assert property (!(ired_o && led_o))
    else $error("emitter and indicator on together");
  chk_io_local: assert property ((clk_en_i && local_r) |=> (!io_oe_n_o && io_o))
    else $error("interconnect not driven in local alarm");
  chk_dump_len: assert property (($fell(dmp_pin) && io_oe_n_o) |-> dmp_len_r == 8'h60)
    else $error("discharge length wrong");
  chk_led_remote: assert property
    ((clk_en_i && remote && !local_r && !in_test) |=> !led_o)
    else $error("indicator pulse during remote alarm");
  chk_code_local: assert property
    ((clk_en_i && local_r) |=> sound_o == `SMK_CODE_LOCAL)
    else $error("local alarm code missing");
  chk_warn_pulse: assert property
    ((clk_en_i && sound_o == `SMK_CODE_LOWBAT) |=> sound_o != `SMK_CODE_LOWBAT)
    else $error("warning code held too long");
  chk_fail_window: assert property
    ($rose(sound_o == `SMK_CODE_FAIL) |-> (rel_age > `SMK_FAIL_MIN && rel_age <= `SMK_FAIL_MAX))
    else $error("failed-test code outside window");
  chk_test_gain: assert property
    ((clk_en_i && state_r == ST_TEST) |=> (high_gain_cap_o && !low_gain_cap_o))
    else $error("high gain not selected in test");
endmodule // smk_seq
